// [tcm_defs.svh]
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

// Register byte addresses
`define TCM_OFF_IRQ 12'hFC0
`define TCM_OFF_IMASK 12'hFC4
`define TCM_OFF_ICTL 12'hFC8
`define TCM_TMR_BASE 6'h3C
`define TCM_SUB_CTL 5'h00
`define TCM_SUB_CNTH 5'h04
`define TCM_SUB_CNTL 5'h08
`define TCM_SUB_RLDH 5'h0C
`define TCM_SUB_RLDL 5'h10

// Control fields
`define TCM_CTL_EN 7
`define TCM_CTL_POL 6
`define TCM_CTL_OE 5
`define TCM_CTL_MHI 3
`define TCM_ICTL_GIE 7

// Interrupt request bit positions
`define TCM_IRQ_TB 6
`define TCM_IRQ_TA 5
`define TCM_IRQ_CONV 0
`define TCM_IRQ_USED 8'h61

// Reset and restart values
`define TCM_CNT_RESTART 16'h0001
`define TCM_CNT_RST 16'h0001
`define TCM_RLD_RST 16'hFFFF
`define TCM_CTL_RST 8'h00

`endif

// [tcm_pkg.sv]
package tcm_pkg;

	typedef enum logic [3:0] {
		MODE_ONE_SHOT,
		MODE_CONTINUOUS,
		MODE_COUNTER,
		MODE_PWM_SINGLE,
		MODE_CAPTURE,
		MODE_COMPARE,
		MODE_GATED,
		MODE_CAPT_CMP,
		MODE_PWM_DUAL,
		MODE_CAPT_RESTART,
		MODE_CMP_COUNTER
	} tcm_mode_t;

	typedef struct packed {
		logic enable;
		logic polarity;
		logic outEn;
		logic modeTop;
		logic [2:0] modeLow;
	} tcm_cfg_t;

endpackage

// [tcm_channel.sv]
`timescale 1ns/1ps
`include "tcm_defs.svh"

module tcm_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration
	input tcm_pkg::tcm_cfg_t cfg,
	input wire logic [15:0] reload,
	input wire logic loadStb,
	input wire logic [15:0] loadVal,
	// Count sources
	input wire logic pinIn,
	input wire logic cmpIn,
	// State
	output logic [15:0] count,
	output logic reloadEvt,
	output logic outLevel
);
	tcm_pkg::tcm_mode_t mode;
	logic srcNow, srcPrev, edgeHit, counting;
	logic prevPinFf, prevCmpFf, evtFf, outFf;
	logic nxt_prevPin, nxt_prevCmp, nxt_evt, nxt_out;
	logic [15:0] cntFf, nxt_cnt;

	always_comb begin
		mode = tcm_pkg::tcm_mode_t'({cfg.modeTop, cfg.modeLow});
		srcNow = (mode == tcm_pkg::MODE_CMP_COUNTER) ? cmpIn : pinIn;
		srcPrev = (mode == tcm_pkg::MODE_CMP_COUNTER) ? prevCmpFf : prevPinFf;
		edgeHit = cfg.polarity ? (srcNow & ~srcPrev) : (~srcNow & srcPrev);
		counting = cfg.enable & ((mode == tcm_pkg::MODE_COUNTER) |
			(mode == tcm_pkg::MODE_CMP_COUNTER));
		nxt_prevPin = pinIn;
		nxt_prevCmp = cmpIn;
		nxt_evt = 1'b0;
		nxt_cnt = cntFf;
		nxt_out = outFf;
		if (!cfg.enable) begin
			nxt_out = cfg.polarity;
		end
		if (loadStb) begin
			nxt_cnt = loadVal;
		end else if (counting && edgeHit) begin
			if (cntFf == reload) begin
				nxt_cnt = `TCM_CNT_RESTART;
				nxt_evt = 1'b1;
				if (cfg.outEn) begin
					nxt_out = ~outFf;
				end
			end else begin
				nxt_cnt = cntFf + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prevPinFf <= 1'b0;
			prevCmpFf <= 1'b0;
			evtFf <= 1'b0;
			outFf <= 1'b0;
			cntFf <= `TCM_CNT_RST;
		end else begin
			prevPinFf <= nxt_prevPin;
			prevCmpFf <= nxt_prevCmp;
			evtFf <= nxt_evt;
			outFf <= nxt_out;
			cntFf <= nxt_cnt;
		end
	end

	assign count = cntFf;
	assign reloadEvt = evtFf;
	assign outLevel = outFf;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_hitReload;
		counting && edgeHit && !loadStb && cntFf == reload;
	endsequence

	a_reload_to_one: assert property (s_hitReload |=> cntFf == 16'h0001 && evtFf)
		else $error("count did not restart at one on reload");
	a_out_toggles: assert property (s_hitReload ##0 cfg.outEn |=> outFf != $past(outFf))
		else $error("output did not toggle at reload");
	a_idle_level: assert property (!cfg.enable && !rst |=> outFf == $past(cfg.polarity))
		else $error("idle output level differs from polarity");
	a_count_step: assert property (counting && edgeHit && !loadStb && cntFf != reload
		|=> cntFf == $past(cntFf) + 16'h0001)
		else $error("count did not advance by one per transition");
	a_cmp_every_edge: assert property (mode == tcm_pkg::MODE_CMP_COUNTER && cfg.enable
		&& cfg.polarity && cmpIn && !prevCmpFf && !loadStb |=> cntFf != $past(cntFf))
		else $error("comparator edge was not counted");
	a_load_first: assert property (loadStb |=> cntFf == $past(loadVal))
		else $error("software start count not loaded");
endmodule

// [tcm_top.sv]
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "tcm_defs.svh"

// Functional notes
// - In event counting, a count equal to reload raises the interrupt and restarts at 0001H.
// - With the output function enabled, the output pin inverts at every reload.
// - Polarity picks the counted edge and sets the output level while disabled.
// - A software start count holds only for the first pass, later passes start at 0001H.
// - Counted transitions equal current count minus start value.
// - Comparator counting counts comparator edges of the selected polarity.
// - Comparator counting bypasses the prescaler, every selected edge counts.
// - Mode is four bits: low field in bits 2..0 and a separate top bit.
// - Codes 0 to 5 are one-shot, continuous, counter, single PWM, capture, compare.
// - Codes 6 to 10 are gated, capture/compare, dual PWM, capture-restart, comparator.
// - Timer B request reads in bit 6, timer A in bit 5 of the request register.
// - Any request sets its flag; global enable and its mask bit forward it, otherwise it stays for polling.
// - Timer A on pin 0 (input, inverted output) and pin 1; timer B on pins 6 and 7.

module tcm_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event sources
	input wire logic cmpOut,
	input wire logic convDone,
	// Port A timer pins
	input wire logic portAPinZeroIn,
	output logic portAPinZeroOut,
	output logic portAPinZeroOe,
	output logic portAPinOneOut,
	output logic portAPinOneOe,
	input wire logic portAPinSixIn,
	output logic portAPinSixOut,
	output logic portAPinSixOe,
	output logic portAPinSevenOut,
	output logic portAPinSevenOe,
	// Interrupt
	output logic irq
);
	localparam int NCH = 2;

	logic [7:0] ctlFf [NCH];
	logic [7:0] nxt_ctl [NCH];
	logic [7:0] holdHiFf [NCH];
	logic [7:0] nxt_holdHi [NCH];
	logic [15:0] rldFf [NCH];
	logic [15:0] nxt_rld [NCH];
	logic [NCH-1:0] loadStb;
	logic [15:0] loadVal [NCH];
	logic [15:0] chCount [NCH];
	logic [NCH-1:0] chEvt;
	logic [NCH-1:0] chOut;
	logic [NCH-1:0] chPin;

	logic [7:0] irqFf, nxt_irq, maskFf, nxt_mask, ictlFf, nxt_ictl;
	logic [31:0] prdataFf, nxt_prdata;
	logic preadyFf, nxt_pready, pslverrFf, nxt_pslverr, irqOutFf, nxt_irqOut;
	logic [3:0] pinOutFf, nxt_pinOut, pinOeFf, nxt_pinOe;
	logic setup, wrEn, hit, isTmr, ch;
	logic [4:0] sub;
	logic [7:0] rdByte, setBits;

	assign chPin[0] = portAPinZeroIn;
	assign chPin[1] = portAPinSixIn;

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			tcm_channel u_ch (
				.clk(clk),
				.rst(rst),
				.cfg(tcm_pkg::tcm_cfg_t'({ctlFf[gi][`TCM_CTL_EN], ctlFf[gi][`TCM_CTL_POL],
					ctlFf[gi][`TCM_CTL_OE], ctlFf[gi][`TCM_CTL_MHI], ctlFf[gi][2:0]})),
				.reload(rldFf[gi]),
				.loadStb(loadStb[gi]),
				.loadVal(loadVal[gi]),
				.pinIn(chPin[gi]),
				.cmpIn(cmpOut),
				.count(chCount[gi]),
				.reloadEvt(chEvt[gi]),
				.outLevel(chOut[gi])
			);
		end
	endgenerate

	// Address decode and read mux
	always_comb begin
		setup = psel & ~penable;
		wrEn = psel & penable & preadyFf & pwrite;
		isTmr = (paddr[11:6] == `TCM_TMR_BASE) & (paddr[1:0] == 2'b00);
		ch = paddr[5];
		sub = paddr[4:0];
		hit = 1'b1;
		rdByte = 8'h00;
		if (isTmr) begin
			case (sub)
				`TCM_SUB_CTL: rdByte = ctlFf[ch];
				`TCM_SUB_CNTH: rdByte = chCount[ch][15:8];
				`TCM_SUB_CNTL: rdByte = chCount[ch][7:0];
				`TCM_SUB_RLDH: rdByte = rldFf[ch][15:8];
				`TCM_SUB_RLDL: rdByte = rldFf[ch][7:0];
				default: hit = 1'b0;
			endcase
		end else begin
			case (paddr)
				`TCM_OFF_IRQ: rdByte = irqFf;
				`TCM_OFF_IMASK: rdByte = maskFf;
				`TCM_OFF_ICTL: rdByte = ictlFf;
				default: hit = 1'b0;
			endcase
		end
	end

	// Bus answer: ready in the first access cycle
	always_comb begin
		nxt_pready = setup;
		nxt_prdata = setup ? {24'h000000, rdByte} : prdataFf;
		nxt_pslverr = setup & ~hit;
	end

	// Timer configuration registers
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			nxt_ctl[i] = ctlFf[i];
			nxt_holdHi[i] = holdHiFf[i];
			nxt_rld[i] = rldFf[i];
			loadStb[i] = 1'b0;
			loadVal[i] = {holdHiFf[i], pwdata[7:0]};
			if (wrEn && isTmr && ch == i[0]) begin
				case (sub)
					`TCM_SUB_CTL: nxt_ctl[i] = pwdata[7:0];
					`TCM_SUB_CNTH: nxt_holdHi[i] = pwdata[7:0];
					`TCM_SUB_CNTL: loadStb[i] = 1'b1;
					`TCM_SUB_RLDH: nxt_rld[i][15:8] = pwdata[7:0];
					`TCM_SUB_RLDL: nxt_rld[i][7:0] = pwdata[7:0];
					default: nxt_ctl[i] = ctlFf[i];
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				ctlFf[i] <= `TCM_CTL_RST;
				holdHiFf[i] <= 8'h00;
				rldFf[i] <= `TCM_RLD_RST;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				ctlFf[i] <= nxt_ctl[i];
				holdHiFf[i] <= nxt_holdHi[i];
				rldFf[i] <= nxt_rld[i];
			end
		end
	end

	// Interrupt flags, mask and global enable
	always_comb begin
		setBits = 8'h00;
		setBits[`TCM_IRQ_TB] = chEvt[1];
		setBits[`TCM_IRQ_TA] = chEvt[0];
		setBits[`TCM_IRQ_CONV] = convDone;
		nxt_irq = irqFf;
		nxt_mask = maskFf;
		nxt_ictl = ictlFf;
		if (wrEn && !isTmr) begin
			case (paddr)
				`TCM_OFF_IRQ: nxt_irq = irqFf & ~pwdata[7:0];
				`TCM_OFF_IMASK: nxt_mask = pwdata[7:0] & `TCM_IRQ_USED;
				`TCM_OFF_ICTL: nxt_ictl = {pwdata[`TCM_ICTL_GIE], 7'h00};
				default: nxt_irq = irqFf;
			endcase
		end
		// set beats clear; reserved bits never set
		nxt_irq = (nxt_irq | setBits) & `TCM_IRQ_USED;
		nxt_irqOut = ictlFf[`TCM_ICTL_GIE] & (|(irqFf & maskFf));
	end

	// Pin drive; shared pins carry the inverted output
	always_comb begin
		nxt_pinOut = {chOut[1], ~chOut[1], chOut[0], ~chOut[0]};
		nxt_pinOe = {ctlFf[1][`TCM_CTL_OE], ctlFf[1][`TCM_CTL_OE],
			ctlFf[0][`TCM_CTL_OE], ctlFf[0][`TCM_CTL_OE]};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqFf <= 8'h00;
			maskFf <= 8'h00;
			ictlFf <= 8'h00;
			irqOutFf <= 1'b0;
			prdataFf <= 32'h00000000;
			preadyFf <= 1'b0;
			pslverrFf <= 1'b0;
			pinOutFf <= 4'h0;
			pinOeFf <= 4'h0;
		end else begin
			irqFf <= nxt_irq;
			maskFf <= nxt_mask;
			ictlFf <= nxt_ictl;
			irqOutFf <= nxt_irqOut;
			prdataFf <= nxt_prdata;
			preadyFf <= nxt_pready;
			pslverrFf <= nxt_pslverr;
			pinOutFf <= nxt_pinOut;
			pinOeFf <= nxt_pinOe;
		end
	end

	assign prdata = prdataFf;
	assign pready = preadyFf;
	assign pslverr = pslverrFf;
	assign irq = irqOutFf;
	assign portAPinZeroOut = pinOutFf[0];
	assign portAPinOneOut = pinOutFf[1];
	assign portAPinSixOut = pinOutFf[2];
	assign portAPinSevenOut = pinOutFf[3];
	assign portAPinZeroOe = pinOeFf[0];
	assign portAPinOneOe = pinOeFf[1];
	assign portAPinSixOe = pinOeFf[2];
	assign portAPinSevenOe = pinOeFf[3];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_flag_b_set: assert property (chEvt[1] |=> irqFf[6])
		else $error("timer B event did not set bit 6");
	a_flag_a_set: assert property (chEvt[0] |=> irqFf[5])
		else $error("timer A event did not set bit 5");
	a_irq_forward: assert property (irqFf[5] && maskFf[5] && ictlFf[7] |=> irq)
		else $error("unmasked request not forwarded");
	a_irq_polled: assert property (!ictlFf[7] |=> !irq)
		else $error("interrupt raised while globally disabled");
	a_pin_map: assert property (pinOeFf[0] |-> portAPinZeroOut != portAPinOneOut)
		else $error("shared pin is not the complement output");
	a_mode_field: assert property (wrEn && isTmr && sub == 5'h00
		|=> ctlFf[$past(ch)][3:0] == $past({pwdata[3], pwdata[2:0]}))
		else $error("mode bits not stored");

	// Bus answer stands for the single access cycle only
	a_ready_once: assert property (setup |=> pready ##1 !pready)
		else $error("ready did not stand for exactly one cycle");
	a_unmapped_err: assert property (setup && !hit |=> pslverr && prdata == 32'h00000000)
		else $error("unmapped access was not refused");
	a_read_flags: assert property (setup && paddr == `TCM_OFF_IRQ
		|=> prdata == {24'h000000, $past(irqFf)})
		else $error("request flags read back wrong");

	// Flags wait for software, only a written one removes them
	a_flags_held: assert property (irqFf[`TCM_IRQ_TB]
		&& !(wrEn && paddr == `TCM_OFF_IRQ && pwdata[`TCM_IRQ_TB]) |=> irqFf[`TCM_IRQ_TB])
		else $error("pending request lost without a clear");
	a_flag_clear: assert property (wrEn && paddr == `TCM_OFF_IRQ
		&& pwdata[`TCM_IRQ_TB] && !chEvt[1] |=> !irqFf[`TCM_IRQ_TB])
		else $error("written one did not clear the request");

	// Only the two counting codes may move the count
	a_mode_hold: assert property (!(ctlFf[0][3:0] inside {tcm_pkg::MODE_COUNTER,
		tcm_pkg::MODE_CMP_COUNTER}) && !loadStb[0] |=> $stable(chCount[0]))
		else $error("count moved in a mode that does not count");
	a_cmp_only: assert property (ctlFf[0][3:0] == tcm_pkg::MODE_CMP_COUNTER
		&& cmpOut == $past(cmpOut) && !loadStb[0] |=> $stable(chCount[0]))
		else $error("comparator counting moved on a steady comparator");
	a_pair_commit: assert property (wrEn && isTmr && !ch && sub == `TCM_SUB_CNTL
		|=> chCount[0] == {$past(holdHiFf[0]), $past(pwdata[7:0])})
		else $error("count pair not committed as one value");

	// Idle level reaches the pins after the channel and the pin stage
	sequence s_idleA;
		!ctlFf[0][`TCM_CTL_EN] ##1 !ctlFf[0][`TCM_CTL_EN];
	endsequence
	sequence s_idleB;
		!ctlFf[1][`TCM_CTL_EN] ##1 !ctlFf[1][`TCM_CTL_EN];
	endsequence
	a_idle_pin_a: assert property (s_idleA
		|=> portAPinOneOut == $past(ctlFf[0][`TCM_CTL_POL], 2))
		else $error("timer A pin idle level differs from polarity");
	a_idle_pin_b: assert property (s_idleB
		|=> portAPinSevenOut == $past(ctlFf[1][`TCM_CTL_POL], 2))
		else $error("timer B pin idle level differs from polarity");
	a_toggle_pin_b: assert property (chEvt[1] && $past(ctlFf[1][`TCM_CTL_OE])
		|=> portAPinSevenOut != $past(portAPinSevenOut))
		else $error("timer B pin did not change at reload");
endmodule

// [tcm_edge_src.sv]
`timescale 1ns/1ps

module tcm_edge_src (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request from the bench
	input wire logic go,
	input wire logic [7:0] nPulse,
	// Pin and comparator level, busy flag
	output logic line,
	output logic busy
);
	logic [9:0] phase_ff;
	logic [9:0] nxt_phase;

	// Comparator and pin edges
	// Four cycles a pulse, so every edge is seen by a per-cycle sampler
	always_comb begin
		nxt_phase = phase_ff;
		if (go && phase_ff == 10'h000) begin
			nxt_phase = {nPulse, 2'h0};
		end else if (phase_ff != 10'h000) begin
			nxt_phase = phase_ff - 10'h001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_ff <= 10'h000;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// Idle low between bursts
	assign line = phase_ff[1];
	assign busy = phase_ff != 10'h000;
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "tcm_defs.svh"

module tb_top;
	logic clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic convDone = 1'b0, go = 1'b0;
	logic pready, pslverr, busy, line, irq, err;
	logic outA0, oeA0, outA1, oeA1, outB6, oeB6, outB7, oeB7;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [7:0] nPulse = 8'h00;
	int err_total = 0, n_checks = 0;
	// Mode code, then count low byte after three pulses from 0001
	logic [11:0] rows [11] = '{12'h001, 12'h101, 12'h204, 12'h301, 12'h401, 12'h501,
		12'h601, 12'h701, 12'h801, 12'h901, 12'hA04};

	tcm_top tcm_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmpOut(line), .convDone(convDone), .portAPinZeroIn(line),
		.portAPinZeroOut(outA0), .portAPinZeroOe(oeA0), .portAPinOneOut(outA1),
		.portAPinOneOe(oeA1), .portAPinSixIn(line), .portAPinSixOut(outB6),
		.portAPinSixOe(oeB6), .portAPinSevenOut(outB7), .portAPinSevenOe(oeB7), .irq(irq));

	tcm_edge_src tcm_edge_src_inst (.clk(clk), .rst(rst), .go(go), .nPulse(nPulse),
		.line(line), .busy(busy));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rdat, {24'h0, exp});
	endtask

	// Disable first, count, reload, then enable last
	task automatic setup(input logic [11:0] b, input logic [7:0] c, input logic [15:0] n,
		input logic [15:0] r);
		apb(1'b1, b, c & 8'h7F);
		apb(1'b1, b + 12'h004, n[15:8]);
		apb(1'b1, b + 12'h008, n[7:0]);
		apb(1'b1, b + 12'h00C, r[15:8]);
		apb(1'b1, b + 12'h010, r[7:0]);
		apb(1'b1, b, c);
	endtask

	task automatic pulse(input logic [7:0] n);
		@(posedge clk);
		go <= 1'b1;
		nPulse <= n;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy !== 1'b0) begin
			@(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic settle;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rchk(`TCM_OFF_IRQ, 8'h00);
		rchk(12'hF08, 8'h01);
		rchk(12'hF10, 8'hFF);
		chk({31'h0, irq}, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 11; i++) begin
			setup(12'hF00, {1'b1, i[3], 2'b00, rows[i][11:8]}, 16'h0001, 16'hFFFF);
			pulse(8'h03);
			rchk(12'hF08, rows[i][7:0]);
		end
		$display("test modes done");
		apb(1'b1, 12'hF00, 8'h60);
		apb(1'b1, 12'hF20, 8'h62);
		settle;
		chk({24'h0, oeA0, oeA1, oeB6, oeB7, outA1, outA0, outB7, outB6}, 32'hFA);
		apb(1'b1, 12'hF20, 8'h22);
		settle;
		chk({30'h0, outB7, outB6}, 32'h1);
		$display("test polarity done");
		setup(12'hF20, 8'hE2, 16'h0003, 16'h0005);
		pulse(8'h02);
		rchk(12'hF28, 8'h05);
		rchk(`TCM_OFF_IRQ, 8'h00);
		pulse(8'h01);
		rchk(12'hF28, 8'h01);
		rchk(12'hF24, 8'h00);
		rchk(`TCM_OFF_IRQ, 8'h40);
		chk({29'h0, outB7, outB6, irq}, 32'h2);
		apb(1'b1, `TCM_OFF_IMASK, 8'h40);
		apb(1'b1, `TCM_OFF_ICTL, 8'h80);
		settle;
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `TCM_OFF_IRQ, 8'h40);
		rchk(`TCM_OFF_IRQ, 8'h00);
		chk({31'h0, irq}, 32'h0);
		pulse(8'h04);
		rchk(12'hF28, 8'h05);
		rchk(`TCM_OFF_IRQ, 8'h00);
		pulse(8'h01);
		rchk(`TCM_OFF_IRQ, 8'h40);
		chk({30'h0, outB7, outB6}, 32'h2);
		$display("test reload done");
		@(posedge clk);
		convDone <= 1'b1;
		@(posedge clk);
		convDone <= 1'b0;
		settle;
		rchk(`TCM_OFF_IRQ, 8'h41);
		apb(1'b1, `TCM_OFF_IRQ, 8'h40);
		settle;
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `TCM_OFF_IMASK, 8'h41);
		settle;
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, 12'hFF0, 8'h00);
		chk({31'h0, err}, 32'h1);
		chk(rdat, 32'h0);
		$display("test irq done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk({23'h0, irq, oeA0, oeA1, oeB6, oeB7, outA1, outA0, outB7, outB6}, 32'h0);
		rchk(`TCM_OFF_IRQ, 8'h00);
		rchk(12'hF28, 8'h01);
		rchk(12'hF30, 8'hFF);
		$display("test mid reset done");
		finish_test;
	end

	// Whole run needs several hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		finish_test;
	end
endmodule
